// [src/spi_ctl_pkg.sv]
// Shared constants, types and helpers of the serial control-phase decoder
`default_nettype none
package spi_ctl_pkg;

    // Frame geometry
    localparam int         OFFSET_BITS  = 16;
    localparam int         BYTE_BITS    = 8;
    localparam logic [2:0] RW_KNOWN_CNT = 3'h5;
    localparam logic [2:0] LAST_BIT_CNT = 3'h7;

    // Sub-block codes in the low two block select bits
    localparam logic [1:0] SUB_COMMON = 2'h0;
    localparam logic [1:0] SUB_REGS   = 2'h1;
    localparam logic [1:0] SUB_TXBUF  = 2'h2;
    localparam logic [1:0] SUB_RXBUF  = 2'h3;
    localparam logic [2:0] SOCKET_ZERO = 3'h0;

    // Direction codes
    localparam logic RW_READ  = 1'b0;
    localparam logic RW_WRITE = 1'b1;

    // Data-phase length modes and their byte counts
    localparam logic [1:0] MODE_VARIABLE = 2'h0;
    localparam logic [1:0] MODE_FIXED1   = 2'h1;
    localparam logic [1:0] MODE_FIXED2   = 2'h2;
    localparam logic [1:0] MODE_FIXED4   = 2'h3;
    localparam logic [2:0] LEN_VARIABLE  = 3'h0;
    localparam logic [2:0] LEN_FIXED1    = 3'h1;
    localparam logic [2:0] LEN_FIXED2    = 3'h2;
    localparam logic [2:0] LEN_FIXED4    = 3'h4;

    // Register map
    localparam int          APB_ADDR_W = 12;
    localparam logic [11:0] REG_CTRL   = 12'h000;
    localparam logic [11:0] REG_STATUS = 12'h004;
    localparam logic [11:0] REG_FRAMES = 12'h008;
    localparam logic [11:0] REG_RSVD   = 12'h00c;

    // Field positions and reset values
    localparam int   CTRL_EN_BIT    = 0;
    localparam logic CTRL_EN_RESET  = 1'b1;
    localparam int   ST_CTRL_LSB    = 0;
    localparam int   ST_SOCKET_LSB  = 8;
    localparam int   ST_SUB_LSB     = 11;
    localparam int   ST_RW_BIT      = 13;
    localparam int   ST_MODE_LSB    = 14;
    localparam int   ST_RSVD_BIT    = 16;
    localparam int   ST_ACTIVE_BIT  = 17;
    localparam int   ST_COMMON_BIT  = 18;

    // Control byte as it arrives, bit 7 first
    typedef struct packed {
        logic [4:0] block_select;
        logic       read_write_select;
        logic [1:0] op_length_mode;
    } ctrl_byte_s;

    // Storage access request towards the block behind the decoder
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [2:0]  socket;
        logic [1:0]  sub_block;
        logic [15:0] offset;
        logic [7:0]  wdata;
    } acc_req_s;

    // Frame phases on the serial clock
    typedef enum logic [1:0] {
        PH_ADDR_HI,
        PH_ADDR_LO,
        PH_CTRL,
        PH_DATA
    } link_phase_e;

    // Reserved code: common sub-block with a nonzero socket
    function automatic logic is_reserved(input logic [4:0] bs);
        return (bs[1:0] == SUB_COMMON) && (bs[4:2] != SOCKET_ZERO);
    endfunction

    // Byte count of the data phase, zero meaning ended by chip select
    function automatic logic [2:0] fixed_len(input logic [1:0] mode);
        logic [2:0] len;
        len = LEN_VARIABLE;
        case (mode)
            MODE_FIXED1: len = LEN_FIXED1;
            MODE_FIXED2: len = LEN_FIXED2;
            MODE_FIXED4: len = LEN_FIXED4;
            default:     len = LEN_VARIABLE;
        endcase
        return len;
    endfunction

endpackage
`default_nettype wire

// [src/sync2.sv]
// Two-flop level synchroniser, one stage pair per bit
`default_nettype none
module sync2 #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Destination clock and synchronous reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // Levels in and out
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // Width must be usable
    if (W < 1) begin : g_bad_width
        $error("sync2 width must be at least one");
    end

    // First stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= RST_VAL;
            q_r    <= RST_VAL;
        end else begin
            meta_r <= d_i;
            q_r    <= meta_r;
        end
    end

    assign q_o = q_r;

endmodule
`default_nettype wire

// [src/spi_frame_control_phase_decoder.sv]
// Serial frame decoder: address, control byte and data phase with APB status
//
// Added by the designer: the address map and the APB slave port.
`default_nettype none
module spi_frame_control_phase_decoder
    import spi_ctl_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Core clock and reset
    input  wire logic                             core_clk_i,
    input  wire logic                             sys_rst_i,
    // APB slave
    input  wire logic [spi_ctl_pkg::APB_ADDR_W-1:0] paddr_i,
    input  wire logic                             psel_i,
    input  wire logic                             penable_i,
    input  wire logic                             pwrite_i,
    input  wire logic [31:0]                      pwdata_i,
    input  wire logic [3:0]                       pstrb_i,
    output logic      [31:0]                      prdata_o,
    output logic                                  pready_o,
    output logic                                  pslverr_o,
    // Serial link pins
    input  wire logic                             sclk_i,
    input  wire logic                             cs_n_i,
    input  wire logic                             mosi_i,
    output logic                                  miso_o,
    output logic                                  miso_oe_n_o,
    // Storage port on the serial clock
    output spi_ctl_pkg::acc_req_s                 acc_o,
    input  wire logic [7:0]                       rd_data_i
);

    // Counter width must fit a status word
    if (CNT_W < 1 || CNT_W > 32) begin : g_bad_cnt
        $error("CNT_W must lie between 1 and 32");
    end

    // Core-domain state
    logic             en_r;
    logic             rsvd_seen_r;
    logic [CNT_W-1:0] frames_r;
    logic [CNT_W-1:0] rsvd_cnt_r;
    ctrl_byte_s       last_ctrl_r;
    logic             tgl_seen_r;
    logic             pready_r;
    logic             pslverr_r;
    logic [31:0]      prdata_r;
    logic [1:0]       core_sync;
    logic             ctrl_evt;
    logic             apb_setup;
    logic             apb_write;
    logic [31:0]      status_word;
    logic [31:0]      rd_word;
    logic             rd_hit;

    // Link-domain state
    logic [1:0]       lnk_sync;
    logic             lrst;
    logic             len;
    link_phase_e      phase_r;
    logic [2:0]       bit_cnt_r;
    logic [6:0]       shift_r;
    logic [15:0]      off_r;
    ctrl_byte_s       ctrl_r;
    logic             rsvd_r;
    logic [2:0]       data_left_r;
    logic [7:0]       tx_byte_r;
    acc_req_s         acc_r;
    ctrl_byte_s       ctrl_hold_r;
    logic             ctrl_tgl_r;
    logic             miso_r;
    logic             oe_n_r;
    logic             last_bit;
    logic [7:0]       rx_byte;
    ctrl_byte_s       rx_ctrl;
    logic             ctrl_done;
    logic             data_read;
    logic             more_bytes;

    // Crossings

    // Toggle and chip select into the core; the held byte is read only after the toggle lands
    sync2 #(
        .W       (2),
        .RST_VAL (2'h1)
    ) u_core_sync (
        .clk_i (core_clk_i),
        .rst_i (sys_rst_i),
        .d_i   ({ctrl_tgl_r, cs_n_i}),
        .q_o   (core_sync)
    );

    // Reset and enable onto the serial clock; they take effect only while it runs
    sync2 #(
        .W       (2),
        .RST_VAL (2'h0)
    ) u_link_sync (
        .clk_i (sclk_i),
        .rst_i (1'b0),
        .d_i   ({sys_rst_i, en_r}),
        .q_o   (lnk_sync)
    );

    assign lrst     = lnk_sync[1];
    assign len      = lnk_sync[0];
    assign ctrl_evt = core_sync[1] ^ tgl_seen_r;

    // APB slave, no wait states on any access

    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pready_r && pwrite_i;

    // Status word from the last decoded control byte
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[ST_CTRL_LSB +: BYTE_BITS] = last_ctrl_r;
        status_word[ST_SOCKET_LSB +: 3]       = last_ctrl_r.block_select[4:2];
        status_word[ST_SUB_LSB +: 2]          = last_ctrl_r.block_select[1:0];
        status_word[ST_RW_BIT]                = last_ctrl_r.read_write_select;
        status_word[ST_MODE_LSB +: 2]         = last_ctrl_r.op_length_mode;
        status_word[ST_RSVD_BIT]              = rsvd_seen_r;
        status_word[ST_ACTIVE_BIT]            = !core_sync[0];
        status_word[ST_COMMON_BIT]            = (last_ctrl_r.block_select == 5'h00);
    end

    // Read mux; unmapped offsets read zero and flag an error
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (paddr_i)
            REG_CTRL:   rd_word[CTRL_EN_BIT] = en_r;
            REG_STATUS: rd_word = status_word;
            REG_FRAMES: rd_word[CNT_W-1:0] = frames_r;
            REG_RSVD:   rd_word[CNT_W-1:0] = rsvd_cnt_r;
            default:    rd_hit = 1'b0;
        endcase
    end

    // Answer prepared in setup, presented in the access phase
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else begin
            pready_r  <= apb_setup;
            if (apb_setup) begin
                pslverr_r <= !rd_hit;
                prdata_r  <= pwrite_i ? 32'h0000_0000 : rd_word;
            end else begin
                pslverr_r <= 1'b0;
                prdata_r  <= 32'h0000_0000;
            end
        end
    end

    // Enable bit; disabling parks the link logic
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            en_r <= CTRL_EN_RESET;
        end else if (apb_write && paddr_i == REG_CTRL && pstrb_i[0]) begin
            en_r <= pwdata_i[CTRL_EN_BIT];
        end
    end

    // Control byte events: capture, frame count, reserved count
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            tgl_seen_r  <= 1'b0;
            last_ctrl_r <= '0;
            frames_r    <= '0;
            rsvd_cnt_r  <= '0;
        end else if (ctrl_evt) begin
            tgl_seen_r  <= core_sync[1];
            last_ctrl_r <= ctrl_hold_r;
            frames_r    <= frames_r + 1'b1;
            if (is_reserved(ctrl_hold_r.block_select)) begin
                rsvd_cnt_r <= rsvd_cnt_r + 1'b1;
            end
        end
    end

    // Sticky flag, write one to clear; a new event wins over the clear
    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            rsvd_seen_r <= 1'b0;
        end else if (ctrl_evt && is_reserved(ctrl_hold_r.block_select)) begin
            rsvd_seen_r <= 1'b1;
        end else if (apb_write && paddr_i == REG_STATUS && pstrb_i[2] && pwdata_i[ST_RSVD_BIT]) begin
            rsvd_seen_r <= 1'b0;
        end
    end

    assign prdata_o  = prdata_r;
    assign pready_o  = pready_r;
    assign pslverr_o = pslverr_r;

    // Link side on the serial clock

    // Byte assembly from the shift register and the bit now on the data line
    assign last_bit   = (bit_cnt_r == LAST_BIT_CNT);
    assign rx_byte    = {shift_r, mosi_i};
    assign rx_ctrl    = rx_byte;
    assign ctrl_done  = (phase_r == PH_CTRL) && last_bit;
    assign data_read  = (ctrl_r.read_write_select == RW_READ);
    assign more_bytes = (data_left_r == LEN_VARIABLE) || (data_left_r != LEN_FIXED1);

    // Frame sequencer; chip select high ends any frame at once
    always_ff @(posedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            phase_r     <= PH_ADDR_HI;
            bit_cnt_r   <= 3'h0;
            shift_r     <= 7'h00;
            off_r       <= 16'h0000;
            ctrl_r      <= '0;
            rsvd_r      <= 1'b0;
            data_left_r <= LEN_VARIABLE;
            tx_byte_r   <= 8'h00;
            acc_r       <= '0;
        end else if (lrst || !len) begin
            phase_r     <= PH_ADDR_HI;
            bit_cnt_r   <= 3'h0;
            shift_r     <= 7'h00;
            off_r       <= 16'h0000;
            ctrl_r      <= '0;
            rsvd_r      <= 1'b0;
            data_left_r <= LEN_VARIABLE;
            tx_byte_r   <= 8'h00;
            acc_r       <= '0;
        end else begin
            // Requests are single-cycle pulses
            acc_r.rd  <= 1'b0;
            acc_r.wr  <= 1'b0;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            shift_r   <= {shift_r[5:0], mosi_i};
            case (phase_r)
                PH_ADDR_HI: begin
                    if (last_bit) begin
                        off_r[15:8] <= rx_byte;
                        phase_r     <= PH_ADDR_LO;
                    end
                end
                PH_ADDR_LO: begin
                    if (last_bit) begin
                        off_r[7:0] <= rx_byte;
                        phase_r    <= PH_CTRL;
                    end
                end
                PH_CTRL: begin
                    // Direction is known after six bits, early enough to fetch the first byte
                    if (bit_cnt_r == RW_KNOWN_CNT && mosi_i == RW_READ && !is_reserved(shift_r[4:0])) begin
                        acc_r.rd        <= 1'b1;
                        acc_r.socket    <= shift_r[4:2];
                        acc_r.sub_block <= shift_r[1:0];
                        acc_r.offset    <= off_r;
                    end
                    if (last_bit) begin
                        ctrl_r      <= rx_ctrl;
                        rsvd_r      <= is_reserved(rx_ctrl.block_select);
                        data_left_r <= fixed_len(rx_ctrl.op_length_mode);
                        phase_r     <= PH_DATA;
                        tx_byte_r   <= (rx_ctrl.read_write_select == RW_READ &&
                                        !is_reserved(rx_ctrl.block_select)) ? rd_data_i : 8'h00;
                    end
                end
                PH_DATA: begin
                    // Prefetch the next byte; variable length may fetch one past the end
                    if (bit_cnt_r == RW_KNOWN_CNT && data_read && !rsvd_r && more_bytes) begin
                        acc_r.rd        <= 1'b1;
                        acc_r.socket    <= ctrl_r.block_select[4:2];
                        acc_r.sub_block <= ctrl_r.block_select[1:0];
                        acc_r.offset    <= off_r + 16'h0001;
                    end
                    if (last_bit) begin
                        // Writes to a reserved block are dropped
                        if (!data_read && !rsvd_r) begin
                            acc_r.wr        <= 1'b1;
                            acc_r.socket    <= ctrl_r.block_select[4:2];
                            acc_r.sub_block <= ctrl_r.block_select[1:0];
                            acc_r.offset    <= off_r;
                            acc_r.wdata     <= rx_byte;
                        end
                        off_r     <= off_r + 16'h0001;
                        // Zero after the final byte keeps the line low
                        tx_byte_r <= (data_read && !rsvd_r && more_bytes) ? rd_data_i : 8'h00;
                        if (data_left_r == LEN_FIXED1) begin
                            // Fixed length done: next frame follows without chip select
                            phase_r     <= PH_ADDR_HI;
                            data_left_r <= LEN_VARIABLE;
                        end else if (data_left_r != LEN_VARIABLE) begin
                            data_left_r <= data_left_r - 3'h1;
                        end
                    end
                end
                default: begin
                    phase_r <= PH_ADDR_HI;
                end
            endcase
        end
    end

    // Publish each control byte to the core; survives chip select so no false toggle
    always_ff @(posedge sclk_i) begin
        if (lrst) begin
            ctrl_hold_r <= '0;
            ctrl_tgl_r  <= 1'b0;
        end else if (ctrl_done && len) begin
            ctrl_hold_r <= rx_ctrl;
            ctrl_tgl_r  <= !ctrl_tgl_r;
        end
    end

    // Read data goes out on the falling edge, MSB first
    always_ff @(negedge sclk_i or posedge cs_n_i) begin
        if (cs_n_i) begin
            miso_r <= 1'b0;
            oe_n_r <= 1'b1;
        end else begin
            miso_r <= tx_byte_r[~bit_cnt_r];
            oe_n_r <= !(phase_r == PH_DATA && data_read && len && !lrst);
        end
    end

    assign miso_o      = miso_r;
    assign miso_oe_n_o = oe_n_r;
    assign acc_o       = acc_r;

endmodule
`default_nettype wire

// [sim/spi_decoder_asserts.sv]
// Concurrent checks of the control-phase decoder at its ports
`default_nettype none
module spi_decoder_asserts
    import spi_ctl_pkg::*;
#(
    parameter int CNT_W = 16
) (
    // Core side
    input wire logic                             core_clk_i,
    input wire logic                             sys_rst_i,
    input wire logic [spi_ctl_pkg::APB_ADDR_W-1:0] paddr_i,
    input wire logic                             psel_i,
    input wire logic                             penable_i,
    input wire logic [31:0]                      prdata_o,
    input wire logic                             pready_o,
    input wire logic                             pslverr_o,
    // Link side
    input wire logic                             sclk_i,
    input wire logic                             cs_n_i,
    input wire logic                             miso_o,
    input wire logic                             miso_oe_n_o,
    input wire spi_ctl_pkg::acc_req_s            acc_o
);
    // APB setup cycle; first read request of a frame, before data drives
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_first_rd;
        acc_o.rd && miso_oe_n_o;
    endsequence

    a_ready_next: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        s_setup |=> pready_o) else $error("No ready after setup");
    a_ready_single: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        pready_o |=> !pready_o) else $error("Ready held too long");
    a_err_map: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
        pready_o |-> (pslverr_o == (paddr_i > REG_RSVD)) && (!pslverr_o || prdata_o == 32'h0))
        else $error("Error response wrong");
    a_rsvd_quiet: assert property (@(posedge sclk_i) disable iff (cs_n_i)
        (acc_o.rd || acc_o.wr) |-> !(acc_o.sub_block == SUB_COMMON && acc_o.socket != SOCKET_ZERO))
        else $error("Access to reserved block");
    a_rw_apart: assert property (@(posedge sclk_i) disable iff (cs_n_i)
        !(acc_o.rd && acc_o.wr)) else $error("Read and write together");
    a_wr_spacing: assert property (@(posedge sclk_i) disable iff (cs_n_i)
        acc_o.wr |=> (!acc_o.wr)[*7]) else $error("Write closer than one byte");
    a_rd_spacing: assert property (@(posedge sclk_i) disable iff (cs_n_i)
        acc_o.rd |=> (!acc_o.rd)[*7]) else $error("Read closer than one byte");
    a_wr_step: assert property (@(posedge sclk_i) disable iff (cs_n_i)
        acc_o.wr ##8 acc_o.wr |-> acc_o.offset == $past(acc_o.offset, 8) + 16'h1)
        else $error("Write offset not advanced");
    a_rd_step: assert property (@(posedge sclk_i) disable iff (cs_n_i)
        acc_o.rd ##8 acc_o.rd |-> acc_o.offset == $past(acc_o.offset, 8) + 16'h1)
        else $error("Read offset not advanced");
    a_oe_start: assert property (@(posedge sclk_i) disable iff (cs_n_i)
        s_first_rd |-> ##3 !miso_oe_n_o) else $error("Read data not driven");
    a_idle_low: assert property (@(posedge sclk_i) disable iff (sys_rst_i)
        miso_oe_n_o |-> !miso_o) else $error("Serial out busy while released");
    a_cs_release: assert property (@(posedge sclk_i) disable iff (sys_rst_i)
        cs_n_i |-> miso_oe_n_o && !acc_o.rd && !acc_o.wr) else $error("Link active without select");
endmodule

bind spi_frame_control_phase_decoder spi_decoder_asserts #(.CNT_W(CNT_W)) u_asserts (
    .core_clk_i, .sys_rst_i, .paddr_i, .psel_i, .penable_i, .prdata_o, .pready_o, .pslverr_o,
    .sclk_i, .cs_n_i, .miso_o, .miso_oe_n_o, .acc_o
);
`default_nettype wire

// [sim/spi_host_model.sv]
// Behavioural host that masters the serial link in mode 0
`default_nettype none
module spi_host_model (
    // Link pins driven by the host
    output var logic sclk_o,
    output var logic cs_n_o,
    output var logic mosi_o
);
    timeunit 1ns;
    timeprecision 100ps;

    // Clock rests low, select high
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // One 6 ns bit cell: data changes while low, sampled on the rise
    task automatic pulse(input logic b);
        mosi_o = b;
        #3 sclk_o = 1'b1;
        #3 sclk_o = 1'b0;
    endtask

    // Clocks with select high so the link synchroniser settles; released data toggles
    task automatic idle(input int n);
        cs_n_o = 1'b1;
        repeat (n) pulse(~mosi_o);
    endtask

    // Offset, control byte, then n data bytes, all MSB first
    task automatic frame(input logic [15:0] off, input logic [7:0] ctl, input logic [31:0] d,
                         input int n, input bit last);
        logic [23:0] hdr;
        hdr = {off, ctl};
        #1.7 cs_n_o = 1'b0;
        for (int i = 23; i >= 0; i--) pulse(hdr[i]);
        for (int i = 8 * n - 1; i >= 0; i--) pulse(d[i]);
        // Select may stay low so fixed frames run on
        if (last) begin
            #2 cs_n_o = 1'b1;
            mosi_o = ~mosi_o;
        end
    endtask
endmodule
`default_nettype wire

// [sim/spi_frame_control_phase_decoder_tb_top.sv]
// Self-checking bench of the serial control-phase decoder
`default_nettype none
module spi_frame_control_phase_decoder_tb_top
    import spi_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        core_clk_i = 1'b0;
    logic        sys_rst_i  = 1'b1;
    logic [11:0] paddr_i    = 12'h000;
    logic        psel_i     = 1'b0;
    logic        penable_i  = 1'b0;
    logic        pwrite_i   = 1'b0;
    logic [31:0] pwdata_i   = 32'h0;
    logic [3:0]  pstrb_i    = 4'hf;
    logic [31:0] prdata_o;
    logic        pready_o, pslverr_o, sclk_i, cs_n_i, mosi_i, miso_o, miso_oe_n_o;
    acc_req_s    acc_o;
    logic [7:0]  rd_data_i, rx, last_c;
    logic [33:0] exp_apb[$];
    logic [28:0] exp_wr[$];
    logic [7:0]  exp_miso[$];
    int          errors = 0, comparisons = 0, nbit = 0, frames = 0, rsv_cnt = 0;
    bit          en = 1'b1, rsv_seen = 1'b0;
    int          nb[4] = '{3, 1, 2, 4};

    // Storage content is a pattern of block and offset
    function automatic logic [7:0] mem(input logic [4:0] bs, input logic [15:0] off);
        return off[7:0] ^ {bs, 3'h5};
    endfunction
    function automatic logic [31:0] st(input logic [7:0] c, input logic rs);
        return {13'h0, c[7:3] == 5'h0, 1'b0, rs, c[1:0], c[2], c[4:3], c[7:5], c};
    endfunction

    always #10 core_clk_i = ~core_clk_i;
    assign rd_data_i = mem({acc_o.socket, acc_o.sub_block}, acc_o.offset);

    spi_frame_control_phase_decoder #(.CNT_W(16)) dut (.core_clk_i, .sys_rst_i, .paddr_i, .psel_i,
        .penable_i, .pwrite_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .sclk_i, .cs_n_i,
        .mosi_i, .miso_o, .miso_oe_n_o, .acc_o, .rd_data_i);
    spi_host_model u_host (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .mosi_o(mosi_i));

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; the answer is noted for the monitor, data checked if asked
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, input logic chk,
                       input logic err, input logic [31:0] ed);
        @(posedge core_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= wd;
        exp_apb.push_back({chk, err, ed});
        @(posedge core_clk_i);
        penable_i <= 1'b1;
        while (pready_o !== 1'b1) @(posedge core_clk_i);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    // Frame with its expected storage writes and read bytes noted first
    task automatic xfer(input logic [15:0] off, input logic [7:0] c, input logic [31:0] d, input int n,
                        input bit last);
        logic rsv;
        rsv = c[4:3] == SUB_COMMON && c[7:5] != SOCKET_ZERO;
        for (int k = 0; k < n && en; k++) begin
            if (c[2] == RW_WRITE && !rsv) exp_wr.push_back({c[7:3], off + 16'(k), d[8 * (n - 1 - k) +: 8]});
            if (c[2] == RW_READ) exp_miso.push_back(rsv ? 8'h00 : mem(c[7:3], off + 16'(k)));
        end
        if (en) begin
            frames++;
            rsv_cnt += int'(rsv);
            rsv_seen |= rsv;
            last_c = c;
        end
        u_host.frame(off, c, d, n, last);
    endtask

    // APB answers against the oldest note
    always @(posedge core_clk_i) begin
        if (pready_o === 1'b1 && exp_apb.size() == 0) check("apb_spare", 0, 1);
        else if (pready_o === 1'b1) begin
            check("pslverr", 32'(exp_apb[0][32]), 32'(pslverr_o));
            if (exp_apb[0][33]) check("prdata", exp_apb[0][31:0], prdata_o);
            void'(exp_apb.pop_front());
        end
    end
    // Storage writes; the pulse edge catches the last one of a frame too
    always @(posedge acc_o.wr) begin
        if (exp_wr.size() == 0) check("wr_spare", 0, 1);
        else check("wr_access", 32'(exp_wr.pop_front()), 32'(acc_o[28:0]));
    end
    // Serial read bytes, assembled on the rising edge
    always @(posedge sclk_i) begin
        if (cs_n_i === 1'b1) nbit = 0;
        else if (miso_oe_n_o === 1'b0) begin
            rx = {rx[6:0], miso_o};
            nbit++;
            if (nbit == 8 && exp_miso.size() == 0) check("miso_spare", 0, 1);
            else if (nbit == 8) check("miso_byte", 32'(exp_miso.pop_front()), 32'(rx));
            if (nbit == 8) nbit = 0;
        end
    end

    task automatic wrap_up();
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #100us;
        errors++;
        wrap_up();
    end

    initial begin
        void'($urandom(32'haf071b54));
        u_host.idle(6);
        repeat (8) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        u_host.idle(4);
        // Reset values and an unmapped place in both directions
        apb(0, REG_CTRL, 0, 1, 0, 32'h1);
        apb(0, REG_STATUS, 0, 1, 0, st(8'h00, 1'b0));
        apb(0, REG_FRAMES, 0, 1, 0, 32'h0);
        apb(0, REG_RSVD, 0, 1, 0, 32'h0);
        apb(0, 12'h010, 0, 1, 1, 32'h0);
        apb(1, 12'h7fc, $urandom, 0, 1, 32'h0);
        // Every block code, one-byte writes run on with select low
        for (int b = 0; b < 32; b++) xfer(16'($urandom), {5'(b), RW_WRITE, MODE_FIXED1}, $urandom, 1, b == 31);
        xfer(16'($urandom), {5'h0d, RW_WRITE, MODE_FIXED2}, $urandom, 2, 0);
        xfer(16'($urandom), {5'h16, RW_WRITE, MODE_FIXED4}, $urandom, 4, 1);
        xfer(16'hfffe, {5'h1f, RW_WRITE, MODE_VARIABLE}, $urandom, 4, 1);
        // Reads in every length mode, then from a reserved block
        for (int m = 0; m < 4; m++) xfer(16'($urandom), {m == 0 ? 5'h0 : {3'($urandom), 2'(m)}, RW_READ, 2'(m)}, 0, nb[m], m == 0 || m == 3);
        xfer(16'($urandom), {5'h0c, RW_READ, MODE_FIXED2}, 0, 2, 1);
        repeat (10) @(posedge core_clk_i);
        apb(0, REG_STATUS, 0, 1, 0, st(last_c, rsv_seen));
        apb(0, REG_FRAMES, 0, 1, 0, frames);
        apb(0, REG_RSVD, 0, 1, 0, rsv_cnt);
        apb(1, REG_STATUS, 32'h0001_0000, 0, 0, 0);
        apb(0, REG_STATUS, 0, 1, 0, st(last_c, 1'b0));
        // Link disabled: frames pass unseen
        apb(1, REG_CTRL, 0, 0, 0, 0);
        en = 1'b0;
        u_host.idle(4);
        xfer(16'h1234, {5'h01, RW_WRITE, MODE_FIXED1}, 32'ha5, 1, 1);
        xfer(16'h1234, {5'h01, RW_READ, MODE_FIXED1}, 0, 1, 1);
        apb(1, REG_CTRL, 1, 0, 0, 0);
        en = 1'b1;
        u_host.idle(4);
        apb(0, REG_FRAMES, 0, 1, 0, frames);
        @(posedge core_clk_i);
        check("pending", 0, exp_wr.size() + exp_miso.size() + exp_apb.size());
        wrap_up();
    end
endmodule
`default_nettype wire
